// *** src/pmc_pkg.sv ***
// Constants, register map and carrier types of the power mode controller
package pmc_pkg;

  // Clock period in nanoseconds
  localparam int unsigned CLK_PERIOD_NS = 4;

  // Special function register offsets
  localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
  localparam logic [7:0] SLEEP_CONTROL_ADDR = 8'hbe;

  // Power control register layout
  localparam int unsigned POWER_CONTROL_ENTRY_BIT = 0;
  localparam int unsigned POWER_CONTROL_ZERO_BIT  = 1;
  localparam int unsigned POWER_CONTROL_SPARE_LSB = 2;
  localparam int unsigned POWER_CONTROL_SPARE_MSB = 7;
  localparam logic [5:0]  POWER_CONTROL_SPARE_RST = 6'h00;

  // Sleep control register layout, mode-select field
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned MODE_MSB = 1;

  // Mode-select encodings
  localparam logic [1:0] MODE_FULL_POWER  = 2'h0;
  localparam logic [1:0] MODE_LIGHT_SLEEP = 2'h1;
  localparam logic [1:0] MODE_TIMED_SLEEP = 2'h2;
  localparam logic [1:0] MODE_DEEP_SLEEP  = 2'h3;
  localparam logic [1:0] MODE_RST         = 2'h0;

  // Sequence times in nanoseconds and their cycle counts (least times, rounded up)
  localparam int unsigned LIGHT_DOWN_NS = 20;
  localparam int unsigned LIGHT_UP_NS   = 40;
  localparam int unsigned TIMED_DOWN_NS = 100;
  localparam int unsigned TIMED_UP_NS   = 200;
  localparam int unsigned CNT_W         = 8;
  localparam logic [CNT_W-1:0] LIGHT_DOWN_CYC =
    CNT_W'((LIGHT_DOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] LIGHT_UP_CYC =
    CNT_W'((LIGHT_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] TIMED_DOWN_CYC =
    CNT_W'((TIMED_DOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] TIMED_UP_CYC =
    CNT_W'((TIMED_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Synchroniser depth for pin inputs
  localparam int unsigned SYNC_STAGES = 3;

  // Controller states, one-hot
  typedef enum logic [4:0] {
    ST_ACTIVE   = 5'b00001,
    ST_CPU_IDLE = 5'b00010,
    ST_PWR_DOWN = 5'b00100,
    ST_SLEEP    = 5'b01000,
    ST_PWR_UP   = 5'b10000
  } pmc_state_t;

  // Special function register access from the CPU
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmc_sfr_req_t;

  // Power and clock controls driven out of the block
  typedef struct packed {
    logic       regulator_on;
    logic       rc_osc_en;
    logic       crystal_osc_en;
    logic       lf_osc_en;
    logic       cpu_clock_stop;
    logic       io_hold;
    logic       sysclk_crystal;
    logic [1:0] power_mode;
  } pmc_pwr_ctl_t;

  localparam pmc_pwr_ctl_t PWR_CTL_RST = '{
    regulator_on:   1'b1,
    rc_osc_en:      1'b1,
    crystal_osc_en: 1'b1,
    lf_osc_en:      1'b1,
    cpu_clock_stop: 1'b0,
    io_hold:        1'b0,
    sysclk_crystal: 1'b0,
    power_mode:     MODE_FULL_POWER
  };

endpackage

// *** src/pmc_pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pmc_pin_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);
  import pmc_pkg::*;

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;

  // Output moves only when the second and third stages agree
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    always_comb begin
      out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      out_reg <= '0;
    end else begin
      s1_reg  <= pin_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign level_out = out_reg;

endmodule // pmc_pin_sync

// *** src/pmc_power_mode_controller.sv ***
// Power mode controller: sleep entry, power sequences, wake and register access
`timescale 1ns/1ns
module pmc_power_mode_controller (
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  input  wire pmc_pkg::pmc_sfr_req_t  sfr_req,
  output logic [7:0]                  sfr_rdata,
  input  wire logic                   irq_pending,
  input  wire logic                   crystal_select,
  input  wire logic                   port_irq_pin,
  input  wire logic                   timer_expire_pin,
  input  wire logic                   ext_reset_pin,
  output pmc_pkg::pmc_pwr_ctl_t       pwr_ctl,
  output logic                        sleep_entry_bit,
  output logic                        cpu_restart
);
  import pmc_pkg::*;

  pmc_state_t       state_reg;
  pmc_state_t       state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [1:0]       mode_reg;
  logic [1:0]       mode_next;
  logic [5:0]       spare_reg;
  logic [5:0]       spare_next;
  logic             entry_reg;
  logic             entry_next;
  logic             wake_rst_reg;
  logic             wake_rst_next;
  logic             xtal_reg;
  logic             xtal_next;
  logic             rst_seen_reg;
  logic             restart_reg;
  logic             restart_next;
  logic [7:0]       rdata_reg;
  logic [7:0]       rdata_next;
  pmc_pwr_ctl_t     pwr_reg;
  pmc_pwr_ctl_t     pwr_next;

  logic [2:0]       pins_sync;
  logic             port_wake;
  logic             timer_wake;
  logic             reset_wake;
  logic             power_control_wr;
  logic             sleep_wr;
  logic             go;
  logic             wake;
  logic             timed_class;

  pmc_pin_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .pin_in    ({ext_reset_pin, timer_expire_pin, port_irq_pin}),
    .level_out (pins_sync)
  );

  assign port_wake   = pins_sync[0];
  assign timer_wake  = pins_sync[1];
  assign reset_wake  = pins_sync[2];
  assign power_control_wr     = sfr_req.wr && (sfr_req.addr == POWER_CONTROL_ADDR);
  assign sleep_wr    = sfr_req.wr && (sfr_req.addr == SLEEP_CONTROL_ADDR);
  // Entry needs no pending enabled interrupt
  assign go          = power_control_wr && sfr_req.wdata[POWER_CONTROL_ENTRY_BIT] && !irq_pending;
  assign timed_class = mode_reg[1];

  // Wake sources per mode; deep sleep ignores the timer
  always_comb begin
    wake = reset_wake || port_wake;
    if (mode_reg != MODE_DEEP_SLEEP) begin
      wake = wake || timer_wake;
    end
    if (mode_reg == MODE_LIGHT_SLEEP) begin
      wake = wake || irq_pending;
    end
  end

  // Sequencer
  always_comb begin
    state_next    = state_reg;
    cnt_next      = (cnt_reg != '0) ? cnt_reg - CNT_W'(1) : cnt_reg;
    entry_next    = entry_reg;
    wake_rst_next = wake_rst_reg;
    restart_next  = 1'b0;
    case (state_reg)
      ST_ACTIVE: begin
        if (go) begin
          entry_next = 1'b1;
          if (mode_reg == MODE_FULL_POWER) begin
            state_next = ST_CPU_IDLE;
          end else begin
            state_next = ST_PWR_DOWN;
            cnt_next   = timed_class ? TIMED_DOWN_CYC - CNT_W'(1)
                                     : LIGHT_DOWN_CYC - CNT_W'(1);
          end
        end
        restart_next = reset_wake && !rst_seen_reg;
      end
      ST_CPU_IDLE: begin
        if (irq_pending || reset_wake) begin
          state_next   = ST_ACTIVE;
          entry_next   = 1'b0;
          restart_next = reset_wake;
        end
      end
      ST_PWR_DOWN: begin
        if (wake) begin
          state_next    = ST_PWR_UP;
          wake_rst_next = reset_wake;
          cnt_next      = timed_class ? TIMED_UP_CYC - CNT_W'(1)
                                      : LIGHT_UP_CYC - CNT_W'(1);
        end else if (cnt_reg == '0) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          state_next    = ST_PWR_UP;
          wake_rst_next = reset_wake;
          cnt_next      = timed_class ? TIMED_UP_CYC - CNT_W'(1)
                                      : LIGHT_UP_CYC - CNT_W'(1);
        end
      end
      ST_PWR_UP: begin
        if (cnt_reg == '0) begin
          state_next    = ST_ACTIVE;
          entry_next    = 1'b0;
          restart_next  = wake_rst_reg;
          wake_rst_next = 1'b0;
        end
      end
      default: begin
        state_next = ST_ACTIVE;
        entry_next = 1'b0;
      end
    endcase
  end

  // Register file; values live across sleep, but the mode returns to full power at the end of power-up
  always_comb begin
    mode_next  = mode_reg;
    spare_next = spare_reg;
    if (sleep_wr && (state_reg == ST_ACTIVE)) begin
      mode_next = sfr_req.wdata[MODE_MSB:MODE_LSB];
    end
    if (power_control_wr) begin
      spare_next = sfr_req.wdata[POWER_CONTROL_SPARE_MSB:POWER_CONTROL_SPARE_LSB];
    end
    if ((state_reg == ST_PWR_UP) && (state_next == ST_ACTIVE)) begin
      mode_next = MODE_FULL_POWER;
    end
    rdata_next = 8'h00;
    if (sfr_req.rd && (sfr_req.addr == POWER_CONTROL_ADDR)) begin
      rdata_next = {spare_reg, 2'b00};
    end else if (sfr_req.rd && (sfr_req.addr == SLEEP_CONTROL_ADDR)) begin
      rdata_next = {6'h00, mode_reg};
    end
  end

  // Clock source: RC after each power-up sequence, crystal once software asks
  always_comb begin
    xtal_next = xtal_reg;
    if (state_reg == ST_PWR_UP) begin
      xtal_next = 1'b0;
    end else if ((state_reg == ST_ACTIVE) && crystal_select) begin
      xtal_next = 1'b1;
    end
  end

  // Power controls; regulator is switched off in timed and deep sleep
  always_comb begin
    pwr_next                = PWR_CTL_RST;
    pwr_next.sysclk_crystal = xtal_next;
    pwr_next.power_mode     = MODE_FULL_POWER;
    case (state_next)
      ST_ACTIVE: begin
        pwr_next.cpu_clock_stop = 1'b0;
      end
      ST_CPU_IDLE: begin
        pwr_next.cpu_clock_stop = 1'b1;
      end
      ST_PWR_DOWN, ST_PWR_UP: begin
        pwr_next.cpu_clock_stop = 1'b1;
        pwr_next.io_hold        = mode_next[1];
        pwr_next.power_mode     = mode_next;
      end
      ST_SLEEP: begin
        pwr_next.cpu_clock_stop = 1'b1;
        pwr_next.rc_osc_en      = 1'b0;
        pwr_next.crystal_osc_en = 1'b0;
        pwr_next.regulator_on   = !mode_next[1];
        pwr_next.lf_osc_en      = (mode_next != MODE_DEEP_SLEEP);
        pwr_next.io_hold        = mode_next[1];
        pwr_next.power_mode     = mode_next;
      end
      default: begin
        pwr_next.cpu_clock_stop = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg    <= ST_ACTIVE;
      cnt_reg      <= '0;
      mode_reg     <= MODE_RST;
      spare_reg    <= POWER_CONTROL_SPARE_RST;
      entry_reg    <= 1'b0;
      wake_rst_reg <= 1'b0;
      xtal_reg     <= 1'b0;
      rst_seen_reg <= 1'b0;
      restart_reg  <= 1'b0;
      rdata_reg    <= 8'h00;
      pwr_reg      <= PWR_CTL_RST;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      mode_reg     <= mode_next;
      spare_reg    <= spare_next;
      entry_reg    <= entry_next;
      wake_rst_reg <= wake_rst_next;
      xtal_reg     <= xtal_next;
      rst_seen_reg <= reset_wake;
      restart_reg  <= restart_next;
      rdata_reg    <= rdata_next;
      pwr_reg      <= pwr_next;
    end
  end

  assign sfr_rdata       = rdata_reg;
  assign pwr_ctl         = pwr_reg;
  assign sleep_entry_bit = entry_reg;
  assign cpu_restart     = restart_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_entry_reads_zero;
    sfr_req.rd && (sfr_req.addr == POWER_CONTROL_ADDR) |=> sfr_rdata[1:0] == 2'b00;
  endproperty
  a_entry_reads_zero: assert property (p_entry_reads_zero)
    else $error("power control low bits not read as zero");

  property p_light_sleep_ctl;
    (state_reg == ST_SLEEP) && (mode_reg == MODE_LIGHT_SLEEP) |->
      pwr_ctl.regulator_on && pwr_ctl.lf_osc_en && !pwr_ctl.rc_osc_en
      && !pwr_ctl.crystal_osc_en;
  endproperty
  a_light_sleep_ctl: assert property (p_light_sleep_ctl)
    else $error("light sleep controls wrong");

  property p_deep_sleep_ctl;
    (state_reg == ST_SLEEP) && (mode_reg == MODE_DEEP_SLEEP) |->
      !pwr_ctl.regulator_on && !pwr_ctl.lf_osc_en && !pwr_ctl.rc_osc_en;
  endproperty
  a_deep_sleep_ctl: assert property (p_deep_sleep_ctl)
    else $error("deep sleep left something powered");

  property p_pending_blocks_entry;
    (state_reg == ST_ACTIVE) && power_control_wr && sfr_req.wdata[0] && irq_pending
      |=> (state_reg == ST_ACTIVE) && !sleep_entry_bit;
  endproperty
  a_pending_blocks_entry: assert property (p_pending_blocks_entry)
    else $error("sleep entry taken with interrupt pending");

  property p_wake_clears_mode;
    (state_reg == ST_PWR_UP) && (cnt_reg == '0) |=>
      (mode_reg == MODE_FULL_POWER) && (state_reg == ST_ACTIVE) && !sleep_entry_bit;
  endproperty
  a_wake_clears_mode: assert property (p_wake_clears_mode)
    else $error("mode not cleared on wake");

  property p_io_hold;
    (state_reg == ST_SLEEP) && mode_reg[1] |-> pwr_ctl.io_hold && !pwr_ctl.regulator_on;
  endproperty
  a_io_hold: assert property (p_io_hold)
    else $error("pins not held in timed or deep sleep");

  property p_idle_wake;
    (state_reg == ST_CPU_IDLE) && irq_pending |=>
      (state_reg == ST_ACTIVE) && !pwr_ctl.cpu_clock_stop;
  endproperty
  a_idle_wake: assert property (p_idle_wake)
    else $error("idle CPU not restarted by interrupt");

  property p_light_down_len;
    (state_reg == ST_ACTIVE) && go && (mode_reg == MODE_LIGHT_SLEEP) |=>
      (state_reg == ST_PWR_DOWN || state_reg == ST_PWR_UP)[*5];
  endproperty
  a_light_down_len: assert property (p_light_down_len)
    else $error("light power-down sequence too short");

  property p_rc_after_wake;
    (state_reg == ST_PWR_UP) && (cnt_reg == '0) && !crystal_select
      |=> !pwr_ctl.sysclk_crystal && !xtal_reg;
  endproperty
  a_rc_after_wake: assert property (p_rc_after_wake)
    else $error("system clock not on RC after wake");

endmodule // pmc_power_mode_controller

// *** verification/pmc_wake_source_model.sv ***
// Wake event source model: port, timer and reset pins plus the interrupt line
`timescale 1ns/1ns
module pmc_wake_source_model (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] ev_sel,
  input  wire logic [3:0] ev_delay,
  output logic            port_irq_pin,
  output logic            timer_expire_pin,
  output logic            ext_reset_pin,
  output logic            irq_pending
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [3:0] line_reg;
  logic [3:0] line_next;

  // Events rise after a settable delay and stay until withdrawn
  always_comb begin
    cnt_next  = cnt_reg;
    line_next = line_reg;
    if (ev_sel == 4'h0) begin
      cnt_next  = 4'h0;
      line_next = 4'h0;
    end else if (cnt_reg < ev_delay) begin
      cnt_next = cnt_reg + 4'h1;
    end else begin
      line_next = ev_sel;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg  <= 4'h0;
      line_reg <= 4'h0;
    end else begin
      cnt_reg  <= cnt_next;
      line_reg <= line_next;
    end
  end

  assign port_irq_pin     = line_reg[0];
  assign timer_expire_pin = line_reg[1];
  assign ext_reset_pin    = line_reg[2];
  assign irq_pending      = line_reg[3];
endmodule // pmc_wake_source_model

// *** verification/pmc_power_mode_controller_tb_top.sv ***
// Self-checking testbench of the power mode controller
`timescale 1ns/1ns
module pmc_power_mode_controller_tb_top;
  import pmc_pkg::*;
  logic         sys_clk;
  logic         sys_rst;
  pmc_sfr_req_t sfr_req;
  logic [7:0]   sfr_rdata;
  logic         irq_pending;
  logic         crystal_select;
  logic         port_irq_pin;
  logic         timer_expire_pin;
  logic         ext_reset_pin;
  pmc_pwr_ctl_t pwr_ctl;
  logic         sleep_entry_bit;
  logic         cpu_restart;
  logic [3:0]   ev_sel;
  logic [3:0]   ev_delay;
  logic         rd_q;
  logic [31:0]  seed;
  logic [5:0]   spare;
  logic         xtal_exp;
  logic [8:0]   exp_q[$];
  int           err_count;
  int           samples_checked;
  int           restarts;
  int           n;

  pmc_power_mode_controller DUT (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .irq_pending(irq_pending), .crystal_select(crystal_select),
    .port_irq_pin(port_irq_pin), .timer_expire_pin(timer_expire_pin),
    .ext_reset_pin(ext_reset_pin), .pwr_ctl(pwr_ctl), .sleep_entry_bit(sleep_entry_bit),
    .cpu_restart(cpu_restart)
  );

  pmc_wake_source_model wake (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .ev_sel(ev_sel), .ev_delay(ev_delay),
    .port_irq_pin(port_irq_pin), .timer_expire_pin(timer_expire_pin),
    .ext_reset_pin(ext_reset_pin), .irq_pending(irq_pending)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Counts edges until CPU clock stop (w 0) or RC enable (w 1) reaches v
  task automatic wait_until(input int w, input logic v);
    n = 0;
    while ((w == 0 ? pwr_ctl.cpu_clock_stop : pwr_ctl.rc_osc_en) !== v) begin
      if (n == 300) begin
        err_count++;
        $display("ERROR %0t: wait limit reached", $time);
        print_verdict();
      end
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    sfr_req.wr <= 1'b0;
  endtask

  task automatic sfr_read(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    exp_q.push_back({1'b0, e});
    @(posedge sys_clk);
    sfr_req.rd <= 1'b0;
  endtask

  // Read data arrives one cycle after the strobe is taken
  always @(posedge sys_clk) begin
    if (rd_q === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(9'h1ff, 9'h000, "unexpected read");
      end else begin
        check({1'b0, sfr_rdata}, exp_q.pop_front(), "read data");
      end
    end
    rd_q <= sfr_req.rd;
    if (cpu_restart === 1'b1) begin
      restarts++;
    end
  end

  task automatic sleep_case(input logic [1:0] m, input logic [3:0] decoy,
                            input logic [3:0] src, input int rst_wake);
    logic [8:0] exp;
    int         down;
    int         up;
    int         r0;
    down = (m == MODE_LIGHT_SLEEP) ? int'(LIGHT_DOWN_CYC) : int'(TIMED_DOWN_CYC);
    up   = (m == MODE_LIGHT_SLEEP) ? int'(LIGHT_UP_CYC) : int'(TIMED_UP_CYC);
    exp  = {m == MODE_LIGHT_SLEEP, 2'b00, m != MODE_DEEP_SLEEP, 1'b1,
            m != MODE_LIGHT_SLEEP, xtal_exp, m};
    r0   = restarts;
    sfr_write(SLEEP_CONTROL_ADDR, {6'h00, m});
    sfr_write(POWER_CONTROL_ADDR, {spare, 2'b01});
    #1;
    wait_until(0, 1'b1);
    check({8'h00, sleep_entry_bit}, 9'h001, "entry bit");
    wait_until(1, 1'b0);
    check(9'(n), 9'(down), "power-down cycles");
    check(pwr_ctl, exp, "sleep controls");
    if (decoy != 4'h0) begin
      @(posedge sys_clk);
      ev_sel <= decoy;
      repeat (30) @(posedge sys_clk);
      #1;
      check(pwr_ctl, exp, "deep sleep after timer");
    end
    @(posedge sys_clk);
    ev_delay <= 4'(xs());
    ev_sel   <= src;
    #1;
    wait_until(1, 1'b1);
    wait_until(0, 1'b0);
    check(9'(n), 9'(up), "power-up cycles");
    check(pwr_ctl, PWR_CTL_RST, "full power controls");
    xtal_exp = 1'b0;
    check({8'h00, sleep_entry_bit}, 9'h000, "entry bit cleared");
    @(posedge sys_clk);
    ev_sel <= 4'h0;
    sfr_read(SLEEP_CONTROL_ADDR, {6'h00, MODE_FULL_POWER});
    if (rst_wake == 0) begin
      sfr_read(POWER_CONTROL_ADDR, {spare, 2'b00});
    end
    repeat (8) @(posedge sys_clk);
    check(9'(restarts - r0), 9'(rst_wake), "restart pulses");
  endtask

  initial begin
    sys_rst         = 1'b1;
    sfr_req         = '0;
    crystal_select  = 1'b0;
    ev_sel          = 4'h0;
    ev_delay        = 4'h0;
    rd_q            = 1'b0;
    seed            = 32'h6006;
    spare           = 6'h00;
    xtal_exp        = 1'b0;
    err_count       = 0;
    samples_checked = 0;
    restarts        = 0;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    check(pwr_ctl, PWR_CTL_RST, "reset controls");
    sfr_read(POWER_CONTROL_ADDR, 8'h00);
    sfr_read(SLEEP_CONTROL_ADDR, 8'h00);
    sfr_read(8'h55, 8'h00);
    spare = 6'(xs());
    sfr_write(POWER_CONTROL_ADDR, {spare, 2'b10});
    sfr_read(POWER_CONTROL_ADDR, {spare, 2'b00});
    // System clock source moves to the crystal once software asks
    @(posedge sys_clk);
    crystal_select <= 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    check({8'h00, pwr_ctl.sysclk_crystal}, 9'h001, "crystal source");
    @(posedge sys_clk);
    crystal_select <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    // Crystal stays the source until the next power-up sequence
    check({8'h00, pwr_ctl.sysclk_crystal}, 9'h001, "crystal held");
    xtal_exp = 1'b1;
    // Mode zero entry stops the CPU only, an interrupt restarts it
    sfr_write(SLEEP_CONTROL_ADDR, {6'h00, MODE_FULL_POWER});
    sfr_write(POWER_CONTROL_ADDR, {spare, 2'b01});
    repeat (4) @(posedge sys_clk);
    #1;
    check(pwr_ctl, PWR_CTL_RST | 9'h014, "cpu idle controls");
    @(posedge sys_clk);
    ev_delay <= 4'h0;
    ev_sel   <= 4'h8;
    #1;
    wait_until(0, 1'b0);
    check(9'(n), 9'h002, "idle wake cycles");
    check({8'h00, sleep_entry_bit}, 9'h000, "entry bit after irq");
    // Entry while an interrupt pends is ignored
    sfr_write(SLEEP_CONTROL_ADDR, {6'h00, MODE_LIGHT_SLEEP});
    sfr_write(POWER_CONTROL_ADDR, {spare, 2'b01});
    repeat (4) @(posedge sys_clk);
    #1;
    check(pwr_ctl, PWR_CTL_RST | 9'h004, "entry refused");
    check({8'h00, sleep_entry_bit}, 9'h000, "entry bit refused");
    @(posedge sys_clk);
    ev_sel <= 4'h0;
    repeat (8) @(posedge sys_clk);
    sleep_case(MODE_LIGHT_SLEEP, 4'h0, 4'h2, 0);
    sleep_case(MODE_LIGHT_SLEEP, 4'h0, 4'h8, 0);
    sleep_case(MODE_TIMED_SLEEP, 4'h0, 4'h1, 0);
    sleep_case(MODE_TIMED_SLEEP, 4'h0, 4'h4, 1);
    sleep_case(MODE_DEEP_SLEEP, 4'h2, 4'h1, 0);
    sleep_case(MODE_DEEP_SLEEP, 4'h2, 4'h4, 1);
    repeat (4) @(posedge sys_clk);
    print_verdict();
  end
endmodule // pmc_power_mode_controller_tb_top
